// ---- rtl/pmw_pkg.sv ----
// Constants shared by both ends of the power state and wake control link.
// Assumes one 20 MHz clock for both ends and a 32-bit word register map.
package pmw_pkg;
  // ************************************************************
  // Bus widths and register offsets
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h00;   // power_mgmt_control
  localparam logic [7:0] OFS_INTERRUPT_STATUS = 8'h04;    // interrupt_status
  localparam logic [7:0] OFS_INT_EN = 8'h08;     // interrupt enables
  localparam logic [7:0] OFS_WAKE_TEST = 8'h0c;  // wake_test_register
  localparam logic [7:0] OFS_PHY_BASIC = 8'h10;  // PHY register 0
  localparam logic [7:0] OFS_PHY_MODE = 8'h14;   // PHY register 17
  localparam logic [7:0] OFS_PHY_ISRC = 8'h18;   // PHY interrupt source
  localparam logic [7:0] OFS_PHY_IMASK = 8'h1c;  // PHY interrupt mask
  localparam logic [7:0] OFS_HOST_STS = 8'h40;   // host end status
  localparam logic [7:0] DEV_SPAN = 8'h40;       // addresses below go to the device
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int B_READY = 0;
  localparam int B_PSS_LO = 1;
  localparam int B_WAKEUP_SOURCE_STATUS_LO = 4;
  localparam int B_PULSE_SEL = 6;
  localparam int B_PIN_EN = 8;
  localparam int B_FRAME_EN = 9;
  localparam int B_ENERGY_EN = 10;
  localparam int B_WAKE_IRQ = 0;
  localparam int B_PHY_IRQ = 1;
  localparam int B_PHY_PD = 11;
  localparam int B_EDPD = 13;
  localparam int B_ENERGY_NOW = 1;
  localparam int B_ENERGY_SRC = 1;
  localparam int B_H_READY = 0;
  localparam int B_H_READ_DONE = 1;
  localparam int B_H_REFUSED = 2;
  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] PSS_NORMAL = 2'b00;
  localparam logic [1:0] PSS_WOL = 2'b01;
  localparam logic [1:0] PSS_ENERGY = 2'b10;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_NONE = 2'b00;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_ENERGY = 2'b01;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_FRAME = 2'b10;
  localparam logic [31:0] WAKE_TEST_PATTERN = 32'h1234abcd;  // Arbitrary readback value
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int RESUME_MAX_US = 2000;   // ready within 2 ms
  localparam int PULSE_MS = 50;          // wake pin pulse width
  localparam int RESUME_CYC = (RESUME_MAX_US * 1000) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;
  // ************************************************************
  // Power state machine
  // ************************************************************
  typedef enum logic [2:0]
  {
    PMW_NORMAL = 3'b001,
    PMW_SLEEP_WOL = 3'b010,
    PMW_SLEEP_ENERGY = 3'b100
  } pmw_state_t;
endpackage : pmw_pkg

// ---- rtl/pmw_bus_if.sv ----
// Register link between the host end and the power control device end.
// Assumes both ends run on the same clock; read data follow one cycle after rd.
`timescale 1ns/1ns
interface pmw_bus_if;
  import pmw_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : pmw_bus_if

// ---- rtl/pmw_device.sv ----
// Power state and wake control device end: registers, sleep states, wake pin.
// Assumes the host end keeps access ordering; inputs are synchronous to clk.
// Notes on behaviour
// - Sleep clears ready; only control readable
// - Host avoids other accesses while not ready
// - Writes ignored until a read occurs
// - Select 01 enters frame sleep, gates clocks
// - Frame sleep detects frames, sets status 10
// - Host programs filters before frame sleep
// - Wake flag sets on every enabled wake event
// - Wake test write always returns to normal
// - Energy sleep needs powerdown bit then 10
// - Carrier in energy sleep sets status 01
// - Host clears powerdown bit after ready
// - Flag held while source active; W1C
// - Host interrupt independent of pin enable
// - Pin pulsed 50 ms or held static
// - Pin drops on status or enable clear
// - PHY bit 0.11 powers down PHY
// - Bit 17.13 without energy powers down
// - Energy rise resumes PHY, flags interrupt
// - Ready returns within 2 ms of wake
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module pmw_device
  import pmw_pkg::*;
#(
  parameter int RESUME_CYCLES = RESUME_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC
)
(
  input wire logic clk,                 // 20 MHz clock
  input wire logic nrst,                // Async reset, active low
  pmw_bus_if.dev bus,                   // Register link
  input wire logic wake_frame_det,      // Wake-up frame match pulse
  input wire logic magic_det,           // Magic packet match pulse
  input wire logic line_energy_present, // Line energy level from PHY
  output logic wake_event_pin,          // External wake output, active high
  output logic host_irq,                // Host interrupt, active high
  output logic mac_clk_en,              // MAC clock gate
  output logic host_clk_en,             // Host interface clock gate
  output logic int_clk_en,              // Internal clock gate
  output logic rx_pm_clk_en,            // RX power management clock gate
  output logic phy_powered,             // PHY analog powered
  output logic phy_tx_en,               // PHY may transmit
  output logic phy_reset_pulse,         // PHY self reset on power up
  output logic phy_restore_pulse        // PHY restore after energy wake
);
  // ************************************************************
  // Declarations
  // ************************************************************
  pmw_state_t state_reg;
  logic ready_reg;
  logic read_seen_reg;
  logic [1:0] wakeup_source_status_reg;
  logic pulse_sel_reg, pin_en_reg, frame_en_reg, energy_en_reg;
  logic wake_flag_reg;
  logic [1:0] int_en_reg;
  logic phy_pd_reg, edpd_reg, energy_src_reg, energy_mask_reg;
  logic energy_q_reg, pme_q_reg;
  logic [CNT_W-1:0] resume_cnt_reg;
  logic [CNT_W-1:0] pulse_cnt_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic asleep, wr_ok, pme_int, phy_int;
  logic wr_ctrl, wr_wake, w1c_sts, wr_ien, wr_basic, wr_mode, w1c_isrc, wr_imask;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ************************************************************
  // Access decode
  // ************************************************************
  // Sleep blocks all writes but the wake write
  assign asleep = (state_reg != PMW_NORMAL) || !ready_reg;
  assign wr_ok = bus.wr && read_seen_reg && !asleep;
  assign wr_ctrl = wr_ok && hit(bus.addr, OFS_PWR_CTRL);
  assign wr_wake = bus.wr && hit(bus.addr, OFS_WAKE_TEST) && (state_reg != PMW_NORMAL);
  assign w1c_sts = wr_ok && hit(bus.addr, OFS_INTERRUPT_STATUS);
  assign wr_ien = wr_ok && hit(bus.addr, OFS_INT_EN);
  assign wr_basic = wr_ok && hit(bus.addr, OFS_PHY_BASIC);
  assign wr_mode = wr_ok && hit(bus.addr, OFS_PHY_MODE);
  assign w1c_isrc = wr_ok && hit(bus.addr, OFS_PHY_ISRC);
  assign wr_imask = wr_ok && hit(bus.addr, OFS_PHY_IMASK);

  // A read arms writes; reset and return from sleep disarm them
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      read_seen_reg <= 1'b0;
    else if (wr_wake)
      read_seen_reg <= 1'b0;
    else if (bus.rd)
      read_seen_reg <= 1'b1;

  // ************************************************************
  // Power state and ready
  // ************************************************************
  // Power state follows the select field; wake write forces normal
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      state_reg <= PMW_NORMAL;
    else
    begin
      case (state_reg)
        PMW_NORMAL:
          if (wr_ctrl && bus.wdata[B_PSS_LO +: 2] == PSS_WOL)
            state_reg <= PMW_SLEEP_WOL;
          else if (wr_ctrl && bus.wdata[B_PSS_LO +: 2] == PSS_ENERGY)
            state_reg <= PMW_SLEEP_ENERGY;
        PMW_SLEEP_WOL, PMW_SLEEP_ENERGY:
          if (wr_wake)
            state_reg <= PMW_NORMAL;
        default:
          state_reg <= PMW_NORMAL;
      endcase
    end

  // Ready drops on sleep entry and comes back a fixed time after the wake write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ready_reg <= 1'b1;
      resume_cnt_reg <= CNT_ZERO;
    end
    else if (wr_ctrl && bus.wdata[B_PSS_LO +: 2] != PSS_NORMAL
             && bus.wdata[B_PSS_LO +: 2] != 2'b11)
      ready_reg <= 1'b0;
    else if (wr_wake)
      resume_cnt_reg <= CNT_W'(RESUME_CYCLES - 1);
    else if (state_reg == PMW_NORMAL && !ready_reg)
    begin
      if (resume_cnt_reg == CNT_ZERO)
        ready_reg <= 1'b1;
      else
        resume_cnt_reg <= resume_cnt_reg - CNT_ONE;
    end

  // Clock gates per state; a write of the reserved 11 select keeps normal
  always_comb
  begin
    mac_clk_en = (state_reg == PMW_NORMAL);
    host_clk_en = (state_reg == PMW_NORMAL);
    int_clk_en = (state_reg != PMW_SLEEP_ENERGY);
    rx_pm_clk_en = (state_reg != PMW_SLEEP_ENERGY);
  end

  // ************************************************************
  // Control fields and wake source
  // ************************************************************
  // Plain control bits of the power control register
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      pulse_sel_reg <= 1'b0;
      pin_en_reg <= 1'b0;
      frame_en_reg <= 1'b0;
      energy_en_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      pulse_sel_reg <= bus.wdata[B_PULSE_SEL];
      pin_en_reg <= bus.wdata[B_PIN_EN];
      frame_en_reg <= bus.wdata[B_FRAME_EN];
      energy_en_reg <= bus.wdata[B_ENERGY_EN];
    end

  // Wake source: detection sets, write of ones clears; detection wins
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      wakeup_source_status_reg <= WAKEUP_SOURCE_STATUS_NONE;
    else if (state_reg == PMW_SLEEP_WOL && (wake_frame_det || magic_det))
      wakeup_source_status_reg <= WAKEUP_SOURCE_STATUS_FRAME;
    else if (state_reg == PMW_SLEEP_ENERGY && line_energy_present)
      wakeup_source_status_reg <= WAKEUP_SOURCE_STATUS_ENERGY;
    else if (wr_ctrl)
      wakeup_source_status_reg <= wakeup_source_status_reg & ~bus.wdata[B_WAKEUP_SOURCE_STATUS_LO +: 2];

  // Internal wake source stays up while status and its enable hold
  assign pme_int = (wakeup_source_status_reg[1] && frame_en_reg) || (wakeup_source_status_reg[0] && energy_en_reg);

  // Wake flag is sticky; a clear only takes once the source has gone
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      wake_flag_reg <= 1'b0;
    else if (pme_int)
      wake_flag_reg <= 1'b1;
    else if (w1c_sts && bus.wdata[B_WAKE_IRQ])
      wake_flag_reg <= 1'b0;

  // ************************************************************
  // Wake pin
  // ************************************************************
  // Pulse width counted on clk, restarted by each new event edge
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      pme_q_reg <= 1'b0;
      pulse_cnt_reg <= CNT_ZERO;
    end
    else
    begin
      pme_q_reg <= pme_int;
      if (pme_int && !pme_q_reg)
        pulse_cnt_reg <= CNT_W'(PULSE_CYCLES);
      else if (pulse_cnt_reg != CNT_ZERO)
        pulse_cnt_reg <= pulse_cnt_reg - CNT_ONE;
    end

  // Any clear of status or enables drops the pin one clock after the write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      wake_event_pin <= 1'b0;
    else
      wake_event_pin <= pin_en_reg && pme_int
                        && (!pulse_sel_reg || pulse_cnt_reg != CNT_ZERO);

  // ************************************************************
  // PHY power-down modes
  // ************************************************************
  // PHY control bits, the energy interrupt mask and the interrupt enables
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      phy_pd_reg <= 1'b0;
      edpd_reg <= 1'b0;
      energy_mask_reg <= 1'b0;
      int_en_reg <= 2'b00;
    end
    else
    begin
      if (wr_basic)
        phy_pd_reg <= bus.wdata[B_PHY_PD];
      if (wr_mode)
        edpd_reg <= bus.wdata[B_EDPD];
      if (wr_imask)
        energy_mask_reg <= bus.wdata[B_ENERGY_SRC];
      if (wr_ien)
        int_en_reg <= bus.wdata[1:0];
    end

  // Energy rise while in energy powerdown sets the source; set wins clear
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      energy_q_reg <= 1'b0;
      energy_src_reg <= 1'b0;
    end
    else
    begin
      energy_q_reg <= line_energy_present;
      if (edpd_reg && line_energy_present && !energy_q_reg)
        energy_src_reg <= 1'b1;
      else if (w1c_isrc && bus.wdata[B_ENERGY_SRC])
        energy_src_reg <= 1'b0;
    end

  // PHY power and one-cycle reset and restore strobes
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      phy_reset_pulse <= 1'b0;
      phy_restore_pulse <= 1'b0;
    end
    else
    begin
      phy_reset_pulse <= wr_basic && phy_pd_reg && !bus.wdata[B_PHY_PD];
      phy_restore_pulse <= edpd_reg && line_energy_present && !energy_q_reg;
    end

  // Management stays up in both modes; only analog power is dropped
  assign phy_powered = !phy_pd_reg && !(edpd_reg && !line_energy_present);
  assign phy_tx_en = phy_powered;

  // ************************************************************
  // Interrupt and read data
  // ************************************************************
  assign phy_int = energy_src_reg && energy_mask_reg;
  // Pin enable plays no part in the host interrupt
  assign host_irq = (wake_flag_reg && int_en_reg[B_WAKE_IRQ])
                    || (phy_int && int_en_reg[B_PHY_IRQ]);

  // Registered read data; asleep, only the control register answers
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      rdata_reg <= ZERO_WORD;
    else if (bus.rd)
    begin
      rdata_reg <= ZERO_WORD;
      if (hit(bus.addr, OFS_PWR_CTRL))
      begin
        rdata_reg[B_READY] <= ready_reg;
        rdata_reg[B_PSS_LO +: 2] <= (state_reg == PMW_SLEEP_WOL) ? PSS_WOL :
                                    (state_reg == PMW_SLEEP_ENERGY) ? PSS_ENERGY : PSS_NORMAL;
        rdata_reg[B_WAKEUP_SOURCE_STATUS_LO +: 2] <= wakeup_source_status_reg;
        rdata_reg[B_PULSE_SEL] <= pulse_sel_reg;
        rdata_reg[B_PIN_EN] <= pin_en_reg;
        rdata_reg[B_FRAME_EN] <= frame_en_reg;
        rdata_reg[B_ENERGY_EN] <= energy_en_reg;
      end
      else if (!asleep)
      begin
        if (hit(bus.addr, OFS_INTERRUPT_STATUS))
          rdata_reg[1:0] <= {phy_int, wake_flag_reg};
        else if (hit(bus.addr, OFS_INT_EN))
          rdata_reg[1:0] <= int_en_reg;
        else if (hit(bus.addr, OFS_WAKE_TEST))
          rdata_reg <= WAKE_TEST_PATTERN;
        else if (hit(bus.addr, OFS_PHY_BASIC))
          rdata_reg[B_PHY_PD] <= phy_pd_reg;
        else if (hit(bus.addr, OFS_PHY_MODE))
          rdata_reg[B_EDPD] <= edpd_reg;
        else if (hit(bus.addr, OFS_PHY_ISRC))
          rdata_reg[B_ENERGY_SRC] <= energy_src_reg;
        else if (hit(bus.addr, OFS_PHY_IMASK))
          rdata_reg[B_ENERGY_SRC] <= energy_mask_reg;
      end
    end

  assign bus.rdata = rdata_reg;
  // Live energy level is not readable in bit 1 of PHY mode; it shows only via phy_powered
endmodule : pmw_device

// ---- rtl/pmw_host.sv ----
// Host end: forwards software accesses to the device and guards their order.
// Assumes software drives one strobe per cycle; read data appear one cycle later.
`timescale 1ns/1ns
module pmw_host
  import pmw_pkg::*;
(
  input wire logic clk,                 // 20 MHz clock
  input wire logic nrst,                // Async reset, active low
  pmw_bus_if.host bus,                  // Register link
  input wire logic [ADDR_W-1:0] sw_addr,  // Software address
  input wire logic [DATA_W-1:0] sw_wdata, // Software write data
  input wire logic sw_wr,               // Write strobe
  input wire logic sw_rd,               // Read strobe
  output logic [DATA_W-1:0] sw_rdata    // Read data, cycle after sw_rd
);
  // ************************************************************
  // Tracked device state
  // ************************************************************
  logic ready_reg, read_done_reg, edpd_reg, refused_reg;
  logic snoop_ctrl_reg, local_rd_reg;
  logic [DATA_W-1:0] local_rdata_reg;
  logic to_dev, rd_ok, wr_wake, wr_ok, refuse;

  // Forbidden accesses are dropped here and flagged
  assign to_dev = (sw_addr < DEV_SPAN);
  assign wr_wake = (sw_addr == OFS_WAKE_TEST) && !ready_reg;
  assign rd_ok = ready_reg || (sw_addr == OFS_PWR_CTRL);
  assign wr_ok = wr_wake || (ready_reg && read_done_reg
                 && !(sw_addr == OFS_PWR_CTRL
                      && sw_wdata[B_PSS_LO +: 2] == PSS_ENERGY && !edpd_reg));
  assign refuse = to_dev && ((sw_rd && !rd_ok) || (sw_wr && !wr_ok));

  // Strobes are combinational so read data keep the one-cycle latency
  assign bus.addr = sw_addr;
  assign bus.wdata = sw_wdata;
  assign bus.rd = sw_rd && to_dev && rd_ok;
  assign bus.wr = sw_wr && to_dev && wr_ok;

  // Ready known only from control reads; cleared by any non-normal select write or wake write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ready_reg <= 1'b0;
      snoop_ctrl_reg <= 1'b0;
    end
    else
    begin
      snoop_ctrl_reg <= bus.rd && (sw_addr == OFS_PWR_CTRL);
      if (bus.wr && (wr_wake || (sw_addr == OFS_PWR_CTRL
                     && sw_wdata[B_PSS_LO +: 2] != PSS_NORMAL)))
        ready_reg <= 1'b0;
      else if (snoop_ctrl_reg)
        ready_reg <= bus.rdata[B_READY];
    end

  // Read before write, again after each wake; powerdown bit shadow
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      read_done_reg <= 1'b0;
      edpd_reg <= 1'b0;
    end
    else
    begin
      if (bus.wr && wr_wake)
        read_done_reg <= 1'b0;
      else if (bus.rd)
        read_done_reg <= 1'b1;
      if (bus.wr && sw_addr == OFS_PHY_MODE)
        edpd_reg <= sw_wdata[B_EDPD];
    end

  // Sticky refusal flag; a new refusal wins over the clear
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      refused_reg <= 1'b0;
    else if (refuse)
      refused_reg <= 1'b1;
    else if (sw_wr && sw_addr == OFS_HOST_STS && sw_wdata[B_H_REFUSED])
      refused_reg <= 1'b0;

  // ************************************************************
  // Read return
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      local_rd_reg <= 1'b0;
      local_rdata_reg <= ZERO_WORD;
    end
    else
    begin
      local_rd_reg <= sw_rd && !bus.rd;
      local_rdata_reg <= ZERO_WORD;
      if (sw_rd && sw_addr == OFS_HOST_STS)
      begin
        local_rdata_reg[B_H_READY] <= ready_reg;
        local_rdata_reg[B_H_READ_DONE] <= read_done_reg;
        local_rdata_reg[B_H_REFUSED] <= refused_reg;
      end
    end

  assign sw_rdata = local_rd_reg ? local_rdata_reg : bus.rdata;
endmodule : pmw_host

// ---- verification/pmw_assertions.sv ----
// Checker for the power wake register link between host and device ends.
// Assumes one clock; the test top instantiates it beside the interface.
`timescale 1ns/1ns
module pmw_assertions
  import pmw_pkg::*;
#(
  parameter int RESUME_CYCLES = RESUME_CYC
)
(
  input wire logic clk,                // Link clock
  input wire logic nrst,               // Async reset, active low
  input wire logic [ADDR_W-1:0] addr,  // Address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic wr,                 // Write strobe
  input wire logic rd,                 // Read strobe
  input wire logic [DATA_W-1:0] rdata  // Read data
);
  // ****************
  // Shadow state
  // ****************
  logic asleep;
  logic [1:0] mode;
  logic armed;
  logic rdy_seen;
  logic ctrl_q;
  int wake_cnt;
  wire wake_wr = wr && addr == OFS_WAKE_TEST;
  wire sel_wr = wr && addr == OFS_PWR_CTRL && wdata[2] != wdata[1];
  // Sleep entry on a select write, exit on the wake write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      {asleep, mode} <= 3'h0;
    else if (wake_wr)
      {asleep, mode} <= 3'h0;
    else if (sel_wr && !asleep)
      {asleep, mode} <= {1'b1, wdata[2:1]};
  // Read history; the counter saturates so a long run never wraps it
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      armed <= 1'b0;
      rdy_seen <= 1'b0;
      ctrl_q <= 1'b0;
      wake_cnt <= 100000;
    end
    else
    begin
      armed <= !wake_wr && (armed || rd);
      rdy_seen <= !(wake_wr || sel_wr) && (ctrl_q ? rdata[B_READY] : rdy_seen);
      ctrl_q <= rd && addr == OFS_PWR_CTRL;
      wake_cnt <= wake_wr ? 0 : (wake_cnt < 100000 ? wake_cnt + 1 : wake_cnt);
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_ctrl_rd;
    rd && addr == OFS_PWR_CTRL;
  endsequence
  sequence s_woken;
    !asleep && wake_cnt > RESUME_CYCLES + 1;
  endsequence
  // ****************
  // Properties
  // ****************
  AST_ONE_STROBE: assert property (!(wr && rd))
    else $error("read and write strobes together");
  AST_WR_ARMED: assert property (wr |-> armed || addr == OFS_WAKE_TEST)
    else $error("write reached device before any read");
  AST_SLEEP_WR: assert property (asleep && wr |-> addr == OFS_WAKE_TEST)
    else $error("write other than wake during sleep");
  AST_RD_GUARD: assert property (rd && !rdy_seen |-> addr == OFS_PWR_CTRL)
    else $error("read of other address while not ready");
  AST_SLEEP_CTRL: assert property (asleep ##0 s_ctrl_rd |=> !rdata[0] && rdata[2:1] == mode)
    else $error("sleep control read shows ready or wrong select");
  AST_SLEEP_OTHER: assert property (asleep && rd && addr != OFS_PWR_CTRL |=> rdata == ZERO_WORD)
    else $error("register other than control readable in sleep");
  AST_NORMAL_SEL: assert property (!asleep ##0 s_ctrl_rd |=> rdata[2:1] == PSS_NORMAL)
    else $error("select not normal after wake");
  AST_RESUME: assert property (s_woken ##0 s_ctrl_rd |=> rdata[B_READY])
    else $error("ready late after wake write");
endmodule : pmw_assertions

// ---- verification/power_state_wake_control_test.sv ----
// Self-checking test of host and device ends joined by the register link.
// Assumes the package map; short resume and pulse counts are used.
`timescale 1ns/1ns
module power_state_wake_control_test;
  import pmw_pkg::*;
  localparam int RC = 8;
  localparam int PC = 16;
  localparam logic [31:0] PIN = 32'h100, FRM = 32'h200, NRG = 32'h400, PUL = 32'h40;
  logic clk, nrst, sw_wr, sw_rd, frame_det, magic_det, energy;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, q;
  logic pin, irq, mac_en, host_en, int_en, rx_en, phy_pw, phy_tx, phy_rst, phy_rsto;
  int num_errors, samples_checked, n;
  pmw_bus_if bus_if();
  pmw_host pmw_host_inst(.clk(clk), .nrst(nrst), .bus(bus_if), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  pmw_device #(.RESUME_CYCLES(RC), .PULSE_CYCLES(PC)) pmw_device_inst(.clk(clk),
    .nrst(nrst), .bus(bus_if), .wake_frame_det(frame_det), .magic_det(magic_det),
    .line_energy_present(energy), .wake_event_pin(pin), .host_irq(irq),
    .mac_clk_en(mac_en), .host_clk_en(host_en), .int_clk_en(int_en),
    .rx_pm_clk_en(rx_en), .phy_powered(phy_pw), .phy_tx_en(phy_tx),
    .phy_reset_pulse(phy_rst), .phy_restore_pulse(phy_rsto));
  pmw_assertions #(.RESUME_CYCLES(RC)) pmw_assertions_inst(.clk(clk), .nrst(nrst),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
    .rdata(bus_if.rdata));
  // ****************
  // Bus tasks and checks
  // ****************
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Expected control word after a wake: status field and ready, select back at normal
  function automatic logic [31:0] exp_ctrl(input logic [1:0] wakeup_source_status, input logic rdy);
    exp_ctrl = (32'(wakeup_source_status) << B_WAKEUP_SOURCE_STATUS_LO) | 32'(rdy);
  endfunction : exp_ctrl
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : wrt
  // Data stand from the cycle after the strobe; host status data stand only in that cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    q = sw_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(q & m, e);
  endtask : rdc
  task automatic end_of_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // Polls at two cycles each, so lim bounds the resume time
  task automatic wait_ready(input int lim);
    q = 32'h0;
    for (n = 0; q[0] !== 1'b1; n++)
    begin
      if (n == lim)
      begin
        num_errors++;
        end_of_test();
      end
      rd(OFS_PWR_CTRL);
    end
  endtask : wait_ready
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    {clk, nrst, sw_addr, sw_wdata, sw_wr, sw_rd, frame_det, magic_det, energy} = '0;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(32'hf07a));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(32'({pin, irq, mac_en, host_en, int_en, rx_en, phy_pw}), 32'h1f);
    wrt(OFS_PWR_CTRL, PIN);
    rdc(OFS_PWR_CTRL, 32'hffffffff, 32'h1);
    rdc(OFS_HOST_STS, 32'h6, 32'h6);
    // Frame wake in pulsed mode, then magic wake in static mode
    for (int i = 0; i < 2; i++)
    begin
      wrt(OFS_INT_EN, 32'h1);
      wrt(OFS_PWR_CTRL, PIN | FRM | (i ? 32'h0 : PUL) | 32'h2);
      #1 chk(32'({mac_en, host_en, int_en, rx_en}), 32'h3);
      rdc(OFS_PWR_CTRL, 32'h7, 32'h2);
      rdc(OFS_INTERRUPT_STATUS, 32'hffffffff, 32'h0);
      @(posedge clk) {frame_det, magic_det} <= i ? 2'b01 : 2'b10;
      @(posedge clk) {frame_det, magic_det} <= 2'b00;
      repeat (2) @(posedge clk);
      #1;
      for (n = 0; pin === 1'b1 && n < PC + 8; n++)
        @(posedge clk) #1;
      chk(32'(n), i ? PC + 8 : PC);
      chk(32'(irq), 32'h1);
      wrt(OFS_WAKE_TEST, $urandom());
      wait_ready(6);
      rdc(OFS_PWR_CTRL, 32'h37, exp_ctrl(WAKEUP_SOURCE_STATUS_FRAME, 1'b1));
      wrt(OFS_INTERRUPT_STATUS, 32'h1);
      rdc(OFS_INTERRUPT_STATUS, 32'h1, 32'h1);
      wrt(OFS_PWR_CTRL, PIN | FRM | 32'h30);
      @(posedge clk) #1 chk(32'(pin), 32'h0);
      wrt(OFS_INTERRUPT_STATUS, 32'h1);
      rdc(OFS_INTERRUPT_STATUS, 32'h1, 32'h0);
    end
    // Energy sleep entered with carrier already present
    @(posedge clk) energy <= 1'b1;
    wrt(OFS_PHY_MODE, 32'h2000);
    wrt(OFS_PHY_IMASK, 32'h2);
    wrt(OFS_PWR_CTRL, PIN | NRG | 32'h4);
    #1 chk(32'({mac_en, host_en, int_en, rx_en}), 32'h0);
    repeat (2) @(posedge clk) #1;
    chk(32'(pin), 32'h1);
    wrt(OFS_WAKE_TEST, $urandom());
    wait_ready(6);
    rdc(OFS_PWR_CTRL, 32'h37, exp_ctrl(WAKEUP_SOURCE_STATUS_ENERGY, 1'b1));
    @(posedge clk) energy <= 1'b0;
    @(posedge clk) #1 chk(32'({phy_pw, phy_tx}), 32'h0);
    @(posedge clk) energy <= 1'b1;
    #1 chk(32'(phy_pw), 32'h1);
    @(posedge clk) #1 chk(32'(phy_rsto), 32'h1);
    rdc(OFS_PHY_ISRC, 32'h2, 32'h2);
    wrt(OFS_PHY_MODE, 32'h0);
    wrt(OFS_PWR_CTRL, NRG);
    @(posedge clk) #1 chk(32'({pin, irq}), 32'h1);
    wrt(OFS_PHY_BASIC, 32'h800);
    #1 chk(32'(phy_pw), 32'h0);
    wrt(OFS_PHY_BASIC, 32'h0);
    #1 chk(32'({phy_pw, phy_rst}), 32'h3);
    end_of_test();
  end
endmodule : power_state_wake_control_test
